// *** core/icd_flag_bit.sv ***
// sticky event flag, set wins over write-one-to-clear
`timescale 1ns/1ps
`include "icd_regs.svh"
module icd_flag_bit (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // set and clear
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= `ICD_FLAGS_RST;
      end else if (set) begin
         q <= 1'b1;
      end else if (clr) begin
         q <= 1'b0;
      end
   end

endmodule : icd_flag_bit

// *** core/icd_pkg.sv ***
// types shared by the event mask and detection control logic
package icd_pkg;

   // event vector, bit 7 first
   typedef struct packed {
      logic voltage_limit_event;
      logic contact_timeout_event;
      logic current_limit_event;
      logic thermal_shutdown_event;
      logic bus_good_event;
      logic temp_zone_change_event;
      logic high_temp_event;
      logic temp_shutdown_event;
   } icd_evt_s;

   // detection control register layout
   typedef struct packed {
      logic [1:0] rsvd_hi;
      logic       soft_suspend_n;
      logic       suspend_source_select;
      logic [1:0] rsvd_mid;
      logic       contact_detect_enable;
      logic       rsvd_lo;
   } icd_ctrl_s;

endpackage : icd_pkg

// *** core/icd_regs.svh ***
// register indices, field positions, reset values and behaviour summary
// How it works
// - eight-bit read/write event mask at index 0x08
// - current limit flag passes only when unmasked
// - thermal shutdown flag passes only when unmasked
// - high temperature flag passes only when unmasked
// - temperature shutdown flag gated; one means unmasked
// - detection control at 0x09, bits five four one
// - source select picks pin or software suspend
// - software suspend low forces standby, zero current
// - bus supply rising edge restores detection control
// - contact detect timeout sets its event flag
// - entering high temperature range sets flag
`ifndef ICD_REGS_SVH
`define ICD_REGS_SVH

// register indices; byte address is four times the index
`define ICD_IDX_FLAGS      6'h06
`define ICD_IDX_MASK       6'h08
`define ICD_IDX_CTRL       6'h09

// event bit positions, shared by flags and mask
`define ICD_POS_VLIM       7
`define ICD_POS_DCD_TMO    6
`define ICD_POS_ILIM       5
`define ICD_POS_THRM_SD    4
`define ICD_POS_BUS_GOOD   3
`define ICD_POS_TEMP_ZONE  2
`define ICD_POS_HIGH_TEMP  1
`define ICD_POS_TEMP_SD    0

// detection control field positions
`define ICD_POS_SOFT_SUSP  5
`define ICD_POS_SRC_SEL    4
`define ICD_POS_DCD_EN     1

// reset values and writable bits
`define ICD_MASK_RST       8'h00
`define ICD_FLAGS_RST      1'b0
`define ICD_CTRL_RST       8'h20
`define ICD_CTRL_WMASK     8'h32

`endif

// *** core/icd_rise_det.sv ***
// rising edge detector for a synchronous level
`timescale 1ns/1ps
module icd_rise_det (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // level in, one-cycle pulse out
   input  wire logic level,
   output logic      rise
);

   logic prev_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= level;
      end
   end

   assign rise = level & ~prev_r;

endmodule : icd_rise_det

// *** core/icd_top.sv ***
// event mask, event flags and charger detection control behind apb
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "icd_regs.svh"
module icd_top
   import icd_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // event sources
   input  wire icd_evt_s    evt,
   input  wire logic        temp_high_range,
   // supply and suspend pin
   input  wire logic        bus_supply_input,
   input  wire logic        suspend_input_pin,
   // control outputs
   output logic             force_suspend,
   output logic             contact_detect_en,
   output logic             irq
);

   logic [7:0] mask_r;
   icd_ctrl_s  ctrl_r;
   icd_ctrl_s  ctrl_nxt;
   logic [7:0] flags;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic [7:0] wdata8;
   logic [7:0] rd_nxt;
   logic [5:0] idx;
   logic       setup;
   logic       access_done;
   logic       wr;
   logic       aligned;
   logic       hit_flags;
   logic       hit_mask;
   logic       hit_ctrl;
   logic       mapped;
   logic       bus_rise;
   logic       temp_high_rise;
   logic       susp_nxt;

   // apb decode
   assign setup       = psel & ~penable;
   assign access_done = psel & penable & pready;
   assign idx         = paddr[7:2];
   assign aligned     = (paddr[1:0] == 2'h0);
   assign hit_flags   = aligned & (idx == `ICD_IDX_FLAGS);
   assign hit_mask    = aligned & (idx == `ICD_IDX_MASK);
   assign hit_ctrl    = aligned & (idx == `ICD_IDX_CTRL);
   assign mapped      = hit_flags | hit_mask | hit_ctrl;
   assign wr          = access_done & pwrite & pstrb[0] & mapped;
   assign wdata8      = pwdata[7:0];

   // zero-wait answer: pready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup & ~mapped;
      end
   end

   // read mux, captured in the setup cycle
   always_comb begin
      rd_nxt = 8'h00;
      if (hit_flags) begin
         rd_nxt = flags;
      end else if (hit_mask) begin
         rd_nxt = mask_r;
      end else if (hit_ctrl) begin
         rd_nxt = ctrl_r & `ICD_CTRL_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= {24'h00_0000, rd_nxt};
      end else if (access_done) begin
         prdata <= 32'h0000_0000;
      end
   end

   // event mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= `ICD_MASK_RST;
      end else if (wr && hit_mask) begin
         mask_r <= wdata8;
      end
   end

   // supply rising edge and high temperature entry
   icd_rise_det u_bus_rise (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (bus_supply_input),
      .rise    (bus_rise)
   );

   icd_rise_det u_temp_rise (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (temp_high_range),
      .rise    (temp_high_rise)
   );

   // detection control; supply edge wins over a write
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (bus_rise) begin
         ctrl_nxt = `ICD_CTRL_RST;
      end else if (wr && hit_ctrl) begin
         ctrl_nxt = wdata8 & `ICD_CTRL_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `ICD_CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // sticky flags; masked events are still recorded
   always_comb begin
      set_vec = evt;
      set_vec[`ICD_POS_HIGH_TEMP] = evt.high_temp_event
                                  | temp_high_rise;
      clr_vec = (wr && hit_flags) ? wdata8 : 8'h00;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         icd_flag_bit u_flag (
            .pclk    (pclk),
            .presetn (presetn),
            .set     (set_vec[gi]),
            .clr     (clr_vec[gi]),
            .q       (flags[gi])
         );
      end
   endgenerate

   // interrupt: any flag with its mask bit at one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & mask_r);
      end
   end

   // force suspend source: pin or software bit
   always_comb begin
      if (ctrl_r.suspend_source_select) begin
         susp_nxt = ~ctrl_r.soft_suspend_n;
      end else begin
         susp_nxt = suspend_input_pin;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_suspend <= 1'b0;
      end else begin
         force_suspend <= susp_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         contact_detect_en <= 1'b0;
      end else begin
         contact_detect_en <= ctrl_r.contact_detect_enable;
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_mask_write_store: assert property (
      wr && hit_mask |=> mask_r == $past(wdata8))
      else $error("mask write not stored");

   a_mask_read_back: assert property (
      setup && !pwrite && hit_mask ##1 !$past(wr)
      |-> prdata[7:0] == mask_r && prdata[31:8] == 24'h00_0000)
      else $error("mask read back wrong");

   a_ilim_unmasked: assert property (
      flags[`ICD_POS_ILIM] && mask_r[`ICD_POS_ILIM] |=> irq)
      else $error("current limit event not raised");

   a_ilim_masked: assert property (
      flags == (8'h01 << `ICD_POS_ILIM) && !mask_r[`ICD_POS_ILIM]
      |=> !irq)
      else $error("masked current limit raised irq");

   a_thermal_gate: assert property (
      flags[`ICD_POS_THRM_SD] && mask_r[`ICD_POS_THRM_SD] |=> irq)
      else $error("thermal event not raised");

   a_high_temp_gate: assert property (
      flags[`ICD_POS_HIGH_TEMP] && mask_r[`ICD_POS_HIGH_TEMP] |=> irq)
      else $error("high temperature event not raised");

   a_temp_sd_gate: assert property (
      flags[`ICD_POS_TEMP_SD] && mask_r[`ICD_POS_TEMP_SD] |=> irq)
      else $error("temperature shutdown event not raised");

   a_irq_all_masked: assert property (
      (flags & mask_r) == 8'h00 |=> !irq)
      else $error("irq with no unmasked flag");

   a_flag_kept_masked: assert property (
      evt.current_limit_event && !mask_r[`ICD_POS_ILIM]
      && (flags & mask_r) == 8'h00
      |=> flags[`ICD_POS_ILIM] && !irq)
      else $error("masked event not recorded");

   a_ctrl_write_store: assert property (
      wr && hit_ctrl && !bus_rise
      |=> ctrl_r == ($past(wdata8) & `ICD_CTRL_WMASK)
          ##1 contact_detect_en == $past(ctrl_r.contact_detect_enable))
      else $error("control write not applied");

   a_pin_source: assert property (
      !ctrl_r.suspend_source_select |=>
      force_suspend == $past(suspend_input_pin))
      else $error("pin suspend not followed");

   a_soft_suspend: assert property (
      ctrl_r.suspend_source_select && !ctrl_r.soft_suspend_n
      |=> force_suspend)
      else $error("software suspend not applied");

   a_soft_normal: assert property (
      ctrl_r.suspend_source_select && ctrl_r.soft_suspend_n
      |=> !force_suspend)
      else $error("software normal not applied");

   a_supply_default: assert property (
      $rose(bus_supply_input) |=> ctrl_r == `ICD_CTRL_RST)
      else $error("control not defaulted on supply edge");

   a_timeout_flag: assert property (
      evt.contact_timeout_event |=> flags[`ICD_POS_DCD_TMO])
      else $error("timeout flag not set");

   a_high_temp_flag: assert property (
      $rose(temp_high_range) |=> flags[`ICD_POS_HIGH_TEMP])
      else $error("high temperature flag not set");

   a_set_beats_clear: assert property (
      wr && hit_flags && wdata8[`ICD_POS_VLIM] && evt.voltage_limit_event
      |=> flags[`ICD_POS_VLIM])
      else $error("event lost under clear");

   a_apb_answer: assert property (
      setup |=> pready ##1 !pready || setup)
      else $error("apb answer timing wrong");

   a_vlim_gate: assert property (
      flags[`ICD_POS_VLIM] && mask_r[`ICD_POS_VLIM] |=> irq)
      else $error("voltage limit event not raised");

   a_timeout_gate: assert property (
      flags[`ICD_POS_DCD_TMO] && mask_r[`ICD_POS_DCD_TMO] |=> irq)
      else $error("contact timeout event not raised");

   a_bus_good_gate: assert property (
      flags[`ICD_POS_BUS_GOOD] && mask_r[`ICD_POS_BUS_GOOD] |=> irq)
      else $error("bus good event not raised");

   a_temp_zone_gate: assert property (
      flags[`ICD_POS_TEMP_ZONE] && mask_r[`ICD_POS_TEMP_ZONE] |=> irq)
      else $error("temperature zone event not raised");

   // a one written to a flag clears it unless its event fires again
   a_flag_w1c: assert property (
      wr && hit_flags && (wdata8 & set_vec) == 8'h00
      |=> (flags & $past(wdata8)) == 8'h00)
      else $error("flag not cleared by write of one");

   a_flag_hold: assert property (
      !(wr && hit_flags) && set_vec == 8'h00 |=> flags == $past(flags))
      else $error("flag changed with no event");

   a_mask_hold: assert property (
      !(wr && hit_mask) |=> mask_r == $past(mask_r))
      else $error("mask changed with no write");

   a_ctrl_rsvd_zero: assert property (
      (ctrl_r & ~`ICD_CTRL_WMASK) == 8'h00)
      else $error("reserved control bit set");

   a_detect_follow: assert property (
      1'b1 |=> contact_detect_en == $past(ctrl_r.contact_detect_enable))
      else $error("detect enable not following control");

   // a write without the low byte strobe leaves the mask alone
   a_strobe_ignored: assert property (
      access_done && pwrite && !pstrb[0] |=> mask_r == $past(mask_r))
      else $error("write without byte strobe stored");

   a_unmapped_error: assert property (
      setup && !mapped |=> pready && pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   a_mapped_no_error: assert property (
      setup && mapped |=> !pslverr)
      else $error("mapped access refused");

   a_prdata_idle: assert property (
      access_done |=> prdata == 32'h0000_0000)
      else $error("read data not cleared after access");

   c_irq_raised: cover property (
      !irq ##1 irq ##[1:20] !irq);

   c_soft_suspend: cover property (
      wr && hit_ctrl ##1 ctrl_r.suspend_source_select ##1 force_suspend);

   c_supply_restore: cover property (
      ctrl_r != `ICD_CTRL_RST ##1 bus_rise ##1 ctrl_r == `ICD_CTRL_RST);

   c_unmapped: cover property (pslverr && pready);

   c_set_beats_clear: cover property (
      wr && hit_flags && evt.voltage_limit_event);

endmodule : icd_top

// *** test/icd_top_test.sv ***
// self-checking bench for the event mask and detection control block
`timescale 1ns/1ps
module icd_top_test;
   import icd_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   icd_evt_s    evt;
   logic        temp_high_range;
   logic        bus_supply_input;
   logic        suspend_input_pin;
   logic        force_suspend;
   logic        contact_detect_en;
   logic        irq;
   int          fails;
   int          comparisons;
   logic [31:0] rd;
   logic        err;

   icd_top icd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .evt(evt), .temp_high_range(temp_high_range),
      .bus_supply_input(bus_supply_input),
      .suspend_input_pin(suspend_input_pin), .force_suspend(force_suspend),
      .contact_detect_en(contact_detect_en), .irq(irq));

   always #12.5 pclk = ~pclk;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; waits for pready, takes data at that edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic settle;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask : settle

   task automatic pulse(input logic [7:0] v);
      @(posedge pclk);
      evt <= icd_evt_s'(v);
      @(posedge pclk);
      evt <= icd_evt_s'(8'h00);
      settle;
   endtask : pulse

   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      stop_test;
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      evt = icd_evt_s'(8'h00);
      temp_high_range = 1'b0;
      bus_supply_input = 1'b0;
      suspend_input_pin = 1'b0;
      fails = 0;
      comparisons = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h20, 32'h0); chk(rd, 32'h00);
      apb(1'b0, 8'h24, 32'h0); chk(rd, 32'h20);
      apb(1'b1, 8'h20, 32'hA5);
      apb(1'b0, 8'h20, 32'h0); chk(rd, 32'hA5);
      apb(1'b0, 8'h40, 32'h0); chk({31'h0, err}, 32'h1);
      $display("register defaults test done");
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, 8'h20, 32'h1 << i);
         pulse(8'h01 << i); chk(irq, 1'b1);
         apb(1'b1, 8'h18, 32'h1 << i);
         settle; chk(irq, 1'b0);
         apb(1'b1, 8'h20, ~(32'h1 << i) & 32'hFF);
         pulse(8'h01 << i); chk(irq, 1'b0);
         apb(1'b0, 8'h18, 32'h0); chk(rd, 32'h1 << i);
         apb(1'b1, 8'h18, 32'h1 << i);
      end
      // event held across its own clear: the flag must survive
      evt <= icd_evt_s'(8'h80);
      apb(1'b1, 8'h18, 32'h80);
      evt <= icd_evt_s'(8'h00);
      apb(1'b0, 8'h18, 32'h0); chk(rd, 32'h80);
      apb(1'b1, 8'h18, 32'h80);
      apb(1'b1, 8'h20, 32'h02);
      @(posedge pclk);
      temp_high_range <= 1'b1;
      settle; chk(irq, 1'b1);
      apb(1'b0, 8'h18, 32'h0); chk(rd, 32'h02);
      $display("event mask test done");
      suspend_input_pin <= 1'b1;
      settle; chk(force_suspend, 1'b1);
      apb(1'b1, 8'h24, 32'h30);
      settle; chk(force_suspend, 1'b0);
      apb(1'b1, 8'h24, 32'h10);
      settle; chk(force_suspend, 1'b1);
      @(posedge pclk);
      suspend_input_pin <= 1'b0;
      apb(1'b1, 8'h24, 32'h0);
      settle; chk(force_suspend, 1'b0);
      apb(1'b1, 8'h24, 32'hFF);
      apb(1'b0, 8'h24, 32'h0); chk(rd, 32'h32);
      settle; chk(contact_detect_en, 1'b1);
      @(posedge pclk);
      bus_supply_input <= 1'b1;
      settle;
      apb(1'b0, 8'h24, 32'h0); chk(rd, 32'h20);
      settle; chk(contact_detect_en, 1'b0);
      $display("detection control test done");
      stop_test;
   end
endmodule : icd_top_test
